/* File: bvl_hold_timer.sv */
`timescale 1ns/1ps
module bvl_hold_timer
	import bvl_pkg::*;
#(
	parameter int STEP_CYCLES = BVL_STEP_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// limiter detector
	input wire logic over_thresh_i,
	input wire logic [2:0] hold_code_i,
	// gain state
	output logic attenuate_o
);
	if (STEP_CYCLES < 1) begin : g_bad_step
		$error("bvl_hold_timer: STEP_CYCLES must be at least 1");
	end

	logic [31:0] div_q;
	logic [31:0] div_d;
	logic [2:0] steps_q;
	logic [2:0] steps_d;
	logic over_q;
	logic holding_q;
	logic holding_d;
	wire fall = over_q && !over_thresh_i;
	wire step_tick = holding_q && (div_q == 32'(STEP_CYCLES - 1));

	// step divider runs only while holding
	always_comb begin
		div_d = div_q;
		steps_d = steps_q;
		holding_d = holding_q;
		if (over_thresh_i) begin
			holding_d = 1'b0;
			div_d = '0;
		end else if (fall) begin
			holding_d = (hold_code_i != 3'h0);
			steps_d = hold_code_i;
			div_d = '0;
		end else if (step_tick) begin
			div_d = '0;
			steps_d = steps_q - 3'h1;
			holding_d = (steps_q != 3'h1);
		end else if (holding_q) begin
			div_d = div_q + 32'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_q <= '0;
			steps_q <= '0;
			holding_q <= 1'b0;
			over_q <= 1'b0;
		end else begin
			div_q <= div_d;
			steps_q <= steps_d;
			holding_q <= holding_d;
			over_q <= over_thresh_i;
		end
	end

	// fall term bridges the cycle before holding_q rises
	assign attenuate_o = over_thresh_i || holding_q || (fall && hold_code_i != 3'h0);
endmodule : bvl_hold_timer

/* File: bvl_host_model.sv */
`timescale 1ns/1ps
module bvl_host_model (
	// byte engine side
	input wire logic clk_sys_i,
	input wire logic [7:0] rd_data_i,
	output logic xfer_start_o,
	output logic [15:0] xfer_addr_o,
	output logic wr_byte_o,
	output logic [7:0] wr_data_o,
	output logic rd_byte_o
);
	initial {xfer_start_o, xfer_addr_o, wr_byte_o, wr_data_o, rd_byte_o} = '0;
	task automatic put(input logic [2:0] c, input logic [7:0] d);
		@(negedge clk_sys_i);
		{xfer_start_o, wr_byte_o, rd_byte_o, wr_data_o} = {c, d};
	endtask : put
	task automatic go(input logic [15:0] a);
		xfer_addr_o = a;
		put(3'h4, 8'h00);
	endtask : go
	// both bytes always sent, upper first
	task automatic wr(input logic [15:0] v, input int gap);
		put(3'h2, v[15:8]);
		repeat (gap) put(3'h0, 8'h00);
		put(3'h2, v[7:0]);
		put(3'h0, 8'h00);
	endtask : wr
	task automatic rd(output logic [15:0] v);
		put(3'h1, 8'h00);
		put(3'h1, 8'h00);
		v[15:8] = rd_data_i;
		put(3'h0, 8'h00);
		v[7:0] = rd_data_i;
	endtask : rd
endmodule : bvl_host_model

/* File: bvl_params.sv */
`timescale 1ns/1ps
module bvl_params
	import bvl_pkg::*;
#(
	parameter int STEP_CYCLES = BVL_STEP_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// register access from control-bus byte engine
	input wire logic xfer_start_i,
	input wire logic [15:0] xfer_addr_i,
	input wire logic wr_byte_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_byte_i,
	output logic [7:0] rd_data_o,
	// datapath side
	input wire logic sample_strobe_i,
	input wire logic over_thresh_i,
	output logic signed [27:0] balance_coef_o,
	output logic signed [27:0] volume_coef_o,
	output logic [4:0] post_gain_o,
	output logic limiter_attenuate_o
);
	if (BVL_COEF_W != 28 || BVL_COEF_INT_BITS != 5) begin : g_bad_format
		$error("bvl_params: bad coefficient format");
	end
	if (STEP_CYCLES < 1) begin : g_bad_step
		$error("bvl_params: STEP_CYCLES must be at least 1");
	end

	logic [15:0] ptr_q;
	logic byte_sel_q;
	logic [7:0] wr_hi_q;
	logic [15:0] bal_hi_q;
	logic [15:0] bal_lo_q;
	logic [15:0] vol_hi_q;
	logic [15:0] vol_lo_q;
	logic [15:0] lim_q;
	logic bal_hi_seen_q;
	logic vol_hi_seen_q;
	logic bal_pend_q;
	logic vol_pend_q;
	logic [27:0] bal_stage_q;
	logic [27:0] vol_stage_q;

	// register decode, a transfer start outranks any byte in its cycle
	wire [15:0] wr_word = {wr_hi_q, wr_data_i};
	wire byte_any = (wr_byte_i || rd_byte_i) && !xfer_start_i;
	wire reg_wr = wr_byte_i && byte_sel_q && !xfer_start_i;
	wire reg_done = byte_any && byte_sel_q;
	wire sel_bal_hi = (ptr_q == BVL_ADDR_BAL_HI);
	wire sel_bal_lo = (ptr_q == BVL_ADDR_BAL_LO);
	wire sel_vol_hi = (ptr_q == BVL_ADDR_VOL_HI);
	wire sel_vol_lo = (ptr_q == BVL_ADDR_VOL_LO);
	wire sel_lim = (ptr_q == BVL_ADDR_LIM);
	wire wr_bal_hi = reg_wr && sel_bal_hi;
	wire wr_bal_lo = reg_wr && sel_bal_lo;
	wire wr_vol_hi = reg_wr && sel_vol_hi;
	wire wr_vol_lo = reg_wr && sel_vol_lo;
	wire wr_lim = reg_wr && sel_lim;
	wire bal_commit = wr_bal_lo && bal_hi_seen_q;
	wire vol_commit = wr_vol_lo && vol_hi_seen_q;
	wire bal_pend_d = bal_pend_q || bal_commit;
	wire vol_pend_d = vol_pend_q || vol_commit;
	// whole pair captured at commit, so a later upper write cannot leak in
	wire [27:0] bal_pair = {bal_hi_q[11:0], wr_word};
	wire [27:0] vol_pair = {vol_hi_q[11:0], wr_word};
	wire [27:0] bal_stage_d = bal_commit ? bal_pair : bal_stage_q;
	wire [27:0] vol_stage_d = vol_commit ? vol_pair : vol_stage_q;
	wire [2:0] hold_code = lim_q[BVL_HOLD_MSB:BVL_HOLD_LSB];
	wire [15:0] rd_word =
		sel_bal_hi ? bal_hi_q :
		sel_bal_lo ? bal_lo_q :
		sel_vol_hi ? vol_hi_q :
		sel_vol_lo ? vol_lo_q :
		sel_lim ? lim_q : 16'h0000;
	wire [7:0] rd_byte = byte_sel_q ? rd_word[7:0] : rd_word[15:8];

	// address pointer and byte phase, msb first
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ptr_q <= 16'h0000;
			byte_sel_q <= 1'b0;
		end else if (xfer_start_i) begin
			ptr_q <= xfer_addr_i;
			byte_sel_q <= 1'b0;
		end else if (byte_any) begin
			byte_sel_q <= !byte_sel_q;
			if (reg_done) begin
				ptr_q <= ptr_q + 16'h0001;
			end
		end
	end

	// upper write byte kept until the lower byte completes the word
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_hi_q <= 8'h00;
		end else if (wr_byte_i && !byte_sel_q && !xfer_start_i) begin
			wr_hi_q <= wr_data_i;
		end
	end

	// read byte stands until the next read request
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_byte_i && !xfer_start_i) begin
			rd_data_o <= rd_byte;
		end
	end

	// host-visible registers, reserved bits dropped on write
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bal_hi_q <= BVL_RST_COEF_HI;
		end else if (wr_bal_hi) begin
			bal_hi_q <= wr_word & BVL_MASK_COEF_HI;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bal_lo_q <= BVL_RST_COEF_LO;
		end else if (wr_bal_lo) begin
			bal_lo_q <= wr_word;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vol_hi_q <= BVL_RST_COEF_HI;
		end else if (wr_vol_hi) begin
			vol_hi_q <= wr_word & BVL_MASK_COEF_HI;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vol_lo_q <= BVL_RST_COEF_LO;
		end else if (wr_vol_lo) begin
			vol_lo_q <= wr_word;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lim_q <= BVL_RST_LIM;
		end else if (wr_lim) begin
			lim_q <= wr_word & BVL_MASK_LIM;
		end
	end

	// pair tracking: upper half must precede lower within one transfer
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bal_hi_seen_q <= 1'b0;
		end else if (xfer_start_i) begin
			bal_hi_seen_q <= 1'b0;
		end else if (reg_wr) begin
			bal_hi_seen_q <= sel_bal_hi;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vol_hi_seen_q <= 1'b0;
		end else if (xfer_start_i) begin
			vol_hi_seen_q <= 1'b0;
		end else if (reg_wr) begin
			vol_hi_seen_q <= sel_vol_hi;
		end
	end

	// staging keeps the last complete pair until it is applied
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bal_stage_q <= {BVL_RST_COEF_HI[11:0], BVL_RST_COEF_LO};
			vol_stage_q <= {BVL_RST_COEF_HI[11:0], BVL_RST_COEF_LO};
		end else begin
			bal_stage_q <= bal_stage_d;
			vol_stage_q <= vol_stage_d;
		end
	end

	// apply at sample boundary, a commit in the same cycle goes out at once
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bal_pend_q <= 1'b0;
			balance_coef_o <= 28'(signed'({BVL_RST_COEF_HI[11:0], BVL_RST_COEF_LO}));
		end else if (sample_strobe_i) begin
			bal_pend_q <= 1'b0;
			if (bal_pend_d) begin
				balance_coef_o <= signed'(bal_stage_d);
			end
		end else begin
			bal_pend_q <= bal_pend_d;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vol_pend_q <= 1'b0;
			volume_coef_o <= 28'(signed'({BVL_RST_COEF_HI[11:0], BVL_RST_COEF_LO}));
		end else if (sample_strobe_i) begin
			vol_pend_q <= 1'b0;
			if (vol_pend_d) begin
				volume_coef_o <= signed'(vol_stage_d);
			end
		end else begin
			vol_pend_q <= vol_pend_d;
		end
	end

	assign post_gain_o = lim_q[BVL_GAIN_MSB:BVL_GAIN_LSB];

	bvl_hold_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_hold (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.over_thresh_i(over_thresh_i),
		.hold_code_i(hold_code),
		.attenuate_o(limiter_attenuate_o)
	);
endmodule : bvl_params

/* File: bvl_params_bench.sv */
`timescale 1ns/1ps
module bvl_params_bench;
	import bvl_pkg::*;
	logic clk_sys_i = 1'b0, nrst_i = 1'b0, sample_strobe_i = 1'b0, over_thresh_i = 1'b0;
	logic xfer_start_i, wr_byte_i, rd_byte_i, limiter_attenuate_o;
	logic [15:0] xfer_addr_i, rv;
	logic [7:0] wr_data_i, rd_data_o;
	logic signed [27:0] balance_coef_o, volume_coef_o;
	logic [4:0] post_gain_o;
	int err_count = 0, tests_run = 0, cyc = 0, n;
	logic [2:0] hold [3] = '{3'h0, 3'h1, 3'h7};
	logic [15:0] rst [5] = '{BVL_RST_COEF_HI, BVL_RST_COEF_LO, BVL_RST_COEF_HI, 16'h0000, BVL_RST_LIM};
	logic [47:0] rows [6] = '{{BVL_ADDR_LIM, 16'hffff, 16'h1fe0}, {BVL_ADDR_BAL_HI, 16'hf7ff,
		16'h07ff}, {BVL_ADDR_BAL_LO, 16'ha5c3, 16'ha5c3}, {BVL_ADDR_VOL_HI, 16'h0abc, 16'h0abc},
		{BVL_ADDR_VOL_LO, 16'h5a3c, 16'h5a3c}, {16'h0120, 16'h1234, 16'h0000}};
	always #5 clk_sys_i = ~clk_sys_i;
	bvl_params #(.STEP_CYCLES(4)) bvl_params_inst (.clk_sys_i, .nrst_i, .xfer_start_i, .xfer_addr_i,
		.wr_byte_i, .wr_data_i, .rd_byte_i, .rd_data_o, .sample_strobe_i, .over_thresh_i,
		.balance_coef_o, .volume_coef_o, .post_gain_o, .limiter_attenuate_o);
	bvl_host_model bvl_host_model_inst (.clk_sys_i, .rd_data_i(rd_data_o), .xfer_start_o(xfer_start_i),
		.xfer_addr_o(xfer_addr_i), .wr_byte_o(wr_byte_i), .wr_data_o(wr_data_i), .rd_byte_o(rd_byte_i));
	task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic strobe;
		@(negedge clk_sys_i) sample_strobe_i = 1'b1;
		@(negedge clk_sys_i) sample_strobe_i = 1'b0;
	endtask : strobe
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 3000) begin
			err_count++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (8) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		bvl_host_model_inst.go(BVL_ADDR_BAL_HI);
		foreach (rst[i]) begin
			bvl_host_model_inst.rd(rv);
			chk("reset reg", rst[i], rv);
		end
		chk("reset gain", BVL_GAIN_0DB, post_gain_o);
		foreach (rows[i]) begin
			bvl_host_model_inst.go(rows[i][47:32]);
			bvl_host_model_inst.wr(rows[i][31:16], 0);
			bvl_host_model_inst.go(rows[i][47:32]);
			bvl_host_model_inst.rd(rv);
			chk("readback", rows[i][15:0], rv);
		end
		strobe();
		chk("lone halves", 28'h0800000, balance_coef_o);
		bvl_host_model_inst.go(BVL_ADDR_BAL_HI);
		bvl_host_model_inst.wr(16'h0ff1, 0);
		bvl_host_model_inst.wr(16'h2340, 2);
		bvl_host_model_inst.wr(16'h0008, 0);
		bvl_host_model_inst.wr(16'h0001, 1);
		chk("before strobe", 28'h0800000, volume_coef_o);
		strobe();
		chk("balance", 28'hff12340, balance_coef_o);
		chk("volume", 28'h0080001, volume_coef_o);
		bvl_host_model_inst.go(BVL_ADDR_BAL_HI);
		bvl_host_model_inst.wr(16'h0003, 0);
		bvl_host_model_inst.wr(16'h4567, 0);
		bvl_host_model_inst.go(BVL_ADDR_BAL_HI);
		bvl_host_model_inst.wr(16'h0f00, 0);
		strobe();
		chk("whole pair", 28'h0034567, balance_coef_o);
		foreach (hold[i]) begin
			bvl_host_model_inst.go(BVL_ADDR_LIM);
			bvl_host_model_inst.wr({3'h0, 5'h1e, hold[i], 5'h00}, 0);
			chk("post gain", 28'h1e, post_gain_o);
			@(negedge clk_sys_i) over_thresh_i = 1'b1;
			@(negedge clk_sys_i) over_thresh_i = 1'b0;
			#1 chk("hold at fall", hold[i] != 3'h0, limiter_attenuate_o);
			for (n = 0; n < 40; n++) begin
				@(negedge clk_sys_i);
				if (limiter_attenuate_o !== 1'b1) break;
			end
			chk("hold cycles", hold[i] * 4, n);
		end
		@(negedge clk_sys_i) nrst_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		chk("reset balance", 28'h0800000, balance_coef_o);
		chk("reset gain again", BVL_GAIN_0DB, post_gain_o);
		bvl_host_model_inst.go(BVL_ADDR_LIM);
		bvl_host_model_inst.rd(rv);
		chk("reset limiter", BVL_RST_LIM, rv);
		tally_and_finish();
	end
endmodule : bvl_params_bench

/* File: bvl_params_sva.sv */
`timescale 1ns/1ps
module bvl_params_sva (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// register access
	input wire logic xfer_start_i,
	input wire logic wr_byte_i,
	input wire logic rd_byte_i,
	input wire logic [7:0] rd_data_o,
	// datapath side
	input wire logic sample_strobe_i,
	input wire logic over_thresh_i,
	input wire logic signed [27:0] balance_coef_o,
	input wire logic signed [27:0] volume_coef_o,
	input wire logic [4:0] post_gain_o,
	input wire logic limiter_attenuate_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	a_bal_off_strobe:
		assert property (!sample_strobe_i |=> $stable(balance_coef_o)) else $error("bal moved");
	a_vol_off_strobe:
		assert property (!sample_strobe_i |=> $stable(volume_coef_o)) else $error("vol moved");
	a_vol_cause:
		assert property ($changed(volume_coef_o) |-> $past(sample_strobe_i)) else $error("vol");
	a_atten_over:
		assert property (over_thresh_i |-> limiter_attenuate_o) else $error("atten low");
	a_atten_held:
		assert property (limiter_attenuate_o && !over_thresh_i |-> $past(limiter_attenuate_o))
			else $error("atten rose alone");
	a_gain_by_write:
		assert property ($changed(post_gain_o) |-> $past(wr_byte_i)) else $error("gain moved");
	a_gain_on_start:
		assert property (xfer_start_i |=> $stable(post_gain_o)) else $error("gain on start");
	a_rd_stands:
		assert property (!rd_byte_i |=> $stable(rd_data_o)) else $error("read byte moved");
	c_bal: cover property ($changed(balance_coef_o));
	c_hold: cover property (limiter_attenuate_o && !over_thresh_i);
	c_gain: cover property ($changed(post_gain_o));
endmodule : bvl_params_sva
bind bvl_params bvl_params_sva bvl_params_sva_inst (.clk_sys_i, .nrst_i, .xfer_start_i,
	.wr_byte_i, .rd_byte_i, .rd_data_o, .sample_strobe_i, .over_thresh_i, .balance_coef_o,
	.volume_coef_o, .post_gain_o, .limiter_attenuate_o);

/* File: bvl_pkg.sv */
package bvl_pkg;
	localparam logic [15:0] BVL_ADDR_BAL_HI = 16'h0112;
	localparam logic [15:0] BVL_ADDR_BAL_LO = 16'h0113;
	localparam logic [15:0] BVL_ADDR_VOL_HI = 16'h0114;
	localparam logic [15:0] BVL_ADDR_VOL_LO = 16'h0115;
	localparam logic [15:0] BVL_ADDR_LIM = 16'h0116;
	localparam logic [15:0] BVL_RST_COEF_HI = 16'h0080;
	localparam logic [15:0] BVL_RST_COEF_LO = 16'h0000;
	localparam logic [15:0] BVL_RST_LIM = 16'h0f00;
	localparam logic [15:0] BVL_MASK_COEF_HI = 16'h0fff;
	localparam logic [15:0] BVL_MASK_LIM = 16'h1fe0;
	localparam int BVL_COEF_W = 28;
	localparam int BVL_COEF_INT_BITS = 5;
	localparam int BVL_GAIN_LSB = 8;
	localparam int BVL_GAIN_MSB = 12;
	localparam int BVL_HOLD_LSB = 5;
	localparam int BVL_HOLD_MSB = 7;
	localparam logic [4:0] BVL_GAIN_0DB = 5'h0f;
	localparam int BVL_HOLD_STEP_MS = 10;
	localparam int BVL_CLK_MHZ = 100;
	localparam int BVL_STEP_CYCLES = BVL_HOLD_STEP_MS * 1000 * BVL_CLK_MHZ;
endpackage : bvl_pkg
